// ===== logic/fscr_pkg.sv
// constants and state types for the flash status and configuration registers
package fscr_pkg;

   // ***************************************
   // command opcodes seen on the serial link
   // ***************************************
   localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
   localparam logic [7:0] OP_READ_STATUS    = 8'h05;
   localparam logic [7:0] OP_READ_CONFIG    = 8'h35;
   localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
   localparam logic [7:0] OP_SUSPEND        = 8'hB0;
   localparam logic [7:0] OP_RESUME         = 8'h30;
   localparam logic [7:0] OP_LOCKDOWN_PROT  = 8'h8D;
   localparam logic [7:0] OP_LOCKOUT_SECID  = 8'h85;
   localparam logic [7:0] OP_WRITE_PROT     = 8'h42;
   localparam logic [7:0] OP_QUAD_OUT_READ  = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO_READ   = 8'hEB;
   localparam logic [7:0] OP_WRAP_READ      = 8'hEC;
   localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32;

   // ***************************************
   // status byte bit positions
   // ***************************************
   localparam int STS_BUSY_LO   = 0;
   localparam int STS_WEL       = 1;
   localparam int STS_ERASE_SUS = 2;
   localparam int STS_PROG_SUS  = 3;
   localparam int STS_LOCKDOWN  = 4;
   localparam int STS_SEC_LOCK  = 5;
   localparam int STS_BUSY_HI   = 7;

   // ***************************************
   // configuration byte bit positions
   // ***************************************
   localparam int CFG_PIN_RECONFIG = 1;
   localparam int CFG_VOLATILITY   = 3;
   localparam int CFG_WP_ENABLE    = 7;

   // ***************************************
   // reset values and timing
   // ***************************************
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] CONFIG_RESET   = 8'h08;
   localparam int         CLK_PERIOD_NS  = 8;
   localparam int         ENABLE_WRITE_TIME_NS = 1000;
   localparam int         TIMER_W        = 8;
   // least time, rounded up to whole cycles
   localparam int         ENABLE_WRITE_CYCLES =
      (ENABLE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [TIMER_W-1:0] ENABLE_WRITE_COUNT = TIMER_W'(ENABLE_WRITE_CYCLES);

   // ***************************************
   // state of each clock domain
   // ***************************************
   typedef struct packed {
      logic [2:0]         syncA;
      logic [2:0]         syncB;
      logic [2:0]         syncC;
      logic [2:0]         syncAcc;
      logic               eraseSeen;
      logic               progSeen;
      logic               pendSeen;
      logic               write_enable_latch;
      logic               eraseSusp;
      logic               progSusp;
      logic               lockdown;
      logic               secLocked;
      logic               pinReconfig;
      logic               wpEnable;
      logic [TIMER_W-1:0] wpTimer;
      logic [7:0]         statusSnap;
      logic [7:0]         configSnap;
      logic               busy;
      logic               hwProtect;
      logic               holdEnable;
      logic               suspendReq;
      logic               resumeReq;
      logic               wpStore;
      logic               secStore;
      logic               quadReject;
   } fscr_core_t;

   typedef struct packed {
      logic [2:0] bitCnt;
      logic [1:0] byteCnt;
      logic [6:0] shiftIn;
      logic [7:0] opcode;
      logic       pend;
      logic [7:0] code;
      logic [7:0] arg;
      logic [7:0] shiftOut;
      logic       misoOe;
   } fscr_link_t;

endpackage

// ===== logic/fscr_status_config.sv
// status and configuration register logic with its serial command front end
// Overview of operation
// - erase suspend sets flag, resume clears it
// - program suspend sets flag, resume clears it
// - lock-down flag sets, clears only at power-up
// - security lock flag never clears once set
// - busy while erase, program or write runs
// - eight-bit config, reserved bits read zero
// - bit 1 swaps protect/hold pins for quad data
// - quad commands invalid while bit 1 clear
// - bit 1 ignored in four-wire command mode, still drives quadPinsEnable
// - bit 1 power-up value is factory strap
// - bit 3 reads zero once lock bits set
// - bit 7 nonvolatile, restored at power-up
// - hardware protect: pin low, enable set, bit 1 clear, not four-wire mode
// - enable write runs timed, shows busy
// - hardware protect blocks config writes only
// - status byte bit layout, busy twice
// - write latch auto-clears on listed events
`timescale 1ns/1ps

module fscr_status_config
   import fscr_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic spiClk,
   input  wire logic csN,
   input  wire logic mosi,
   output logic      miso,
   output logic      misoOe,
   input  wire logic wpPinN,
   input  wire logic eraseActive,
   input  wire logic programActive,
   input  wire logic fourWireMode,
   input  wire logic lockBitsAny,
   input  wire logic pinReconfigStrap,
   input  wire logic wpEnableStored,
   input  wire logic secLockedStored,
   output logic      busyOut,
   output logic      hwWriteProtect,
   output logic      holdPinEnable,
   output logic      quadPinsEnable,
   output logic      suspendReq,
   output logic      resumeReq,
   output logic      wpEnableValue,
   output logic      wpEnableStore,
   output logic      secLockStore,
   output logic      quadCmdReject
);

   if (ENABLE_WRITE_CYCLES >= (1 << TIMER_W) || ENABLE_WRITE_CYCLES < 1)
   begin : g_timerCheck
      $error("enable write time does not fit the timer");
   end

   fscr_core_t c_q;
   fscr_core_t c_d;
   fscr_link_t l_q;
   fscr_link_t l_d;
   default clocking cb_core @(posedge clk); endclocking
   default disable iff (rst);

   // ***************************************
   // link domain: serial command shifter
   // ***************************************
   logic [7:0] rxByte;
   logic       isRead;

   always_comb
   begin
      l_d    = l_q;
      rxByte = {l_q.shiftIn, mosi};
      isRead = (l_q.opcode == OP_READ_STATUS) || (l_q.opcode == OP_READ_CONFIG);
      l_d.shiftIn  = rxByte[6:0];
      l_d.bitCnt   = l_q.bitCnt + 3'h1;
      l_d.shiftOut = {l_q.shiftOut[6:0], 1'b0};
      if (l_q.bitCnt == 3'h7)
      begin
         if (l_q.byteCnt != 2'h3)
            l_d.byteCnt = l_q.byteCnt + 2'h1;
         if (l_q.byteCnt == 2'h0)
         begin
            l_d.opcode = rxByte;
            if (rxByte == OP_READ_STATUS)
            begin
               l_d.shiftOut = c_q.statusSnap;
               l_d.misoOe   = 1'b1;
            end
            else if (rxByte == OP_READ_CONFIG)
            begin
               l_d.shiftOut = c_q.configSnap;
               l_d.misoOe   = 1'b1;
            end
            else if (rxByte != OP_WRITE_STATUS)
            begin
               l_d.pend = 1'b1;
               l_d.code = rxByte;
            end
         end
         else if (isRead)
         begin
            // read repeats the same byte until the frame ends
            l_d.shiftOut = (l_q.opcode == OP_READ_STATUS) ? c_q.statusSnap : c_q.configSnap;
         end
         else if (l_q.opcode == OP_WRITE_STATUS && l_q.byteCnt == 2'h2)
         begin
            // first data byte is the read-only status, second the config
            l_d.arg  = rxByte;
            l_d.pend = 1'b1;
            l_d.code = OP_WRITE_STATUS;
         end
      end
   end

   // frame state ends with the frame: chip select high clears it
   always_ff @(posedge spiClk or posedge csN)
      if (csN)
         l_q <= '0;
      else
         l_q <= l_d;

   assign miso   = l_q.shiftOut[7];
   assign misoOe = l_q.misoOe;

   // ***************************************
   // core domain: flags and configuration
   // ***************************************
   logic       cmdNow;
   logic       eraseDone;
   logic       progDone;
   logic [2:0] syncDiff;

   always_comb
   begin
      c_d = c_q;
      // three-stage sampling, a change counts once stages two and three agree
      c_d.syncA   = {l_q.pend, csN, wpPinN};
      c_d.syncB   = c_q.syncA;
      c_d.syncC   = c_q.syncB;
      syncDiff    = c_q.syncB ^ c_q.syncC;
      c_d.syncAcc = (c_q.syncC & ~syncDiff) | (c_q.syncAcc & syncDiff);

      c_d.pendSeen  = c_q.syncAcc[2];
      cmdNow        = c_q.syncAcc[2] && !c_q.pendSeen;
      c_d.eraseSeen = eraseActive;
      c_d.progSeen  = programActive;
      eraseDone     = c_q.eraseSeen && !eraseActive && !c_q.eraseSusp;
      progDone      = c_q.progSeen && !programActive && !c_q.progSusp;
      c_d.suspendReq = 1'b0;
      c_d.resumeReq  = 1'b0;
      c_d.wpStore    = 1'b0;
      c_d.secStore   = 1'b0;
      c_d.quadReject = 1'b0;
      if (c_q.wpTimer != '0)
         c_d.wpTimer = c_q.wpTimer - TIMER_W'(1);
      if (eraseDone || progDone)
         c_d.write_enable_latch = 1'b0;

      if (cmdNow)
      begin
         unique case (l_q.code)
            OP_WRITE_ENABLE:
               c_d.write_enable_latch = 1'b1;
            OP_WRITE_DISABLE, OP_WRITE_PROT:
               c_d.write_enable_latch = 1'b0;
            OP_SUSPEND:
            begin
               c_d.write_enable_latch = 1'b0;
               if (eraseActive)
               begin
                  c_d.eraseSusp  = 1'b1;
                  c_d.suspendReq = 1'b1;
               end
               else if (programActive)
               begin
                  c_d.progSusp   = 1'b1;
                  c_d.suspendReq = 1'b1;
               end
            end
            OP_RESUME:
            begin
               // a program nested in a suspended erase resumes first
               if (c_q.progSusp)
               begin
                  c_d.progSusp  = 1'b0;
                  c_d.resumeReq = 1'b1;
               end
               else if (c_q.eraseSusp)
               begin
                  c_d.eraseSusp = 1'b0;
                  c_d.resumeReq = 1'b1;
               end
            end
            OP_LOCKDOWN_PROT:
            begin
               c_d.write_enable_latch = 1'b0;
               if (c_q.write_enable_latch)
                  c_d.lockdown = 1'b1;
            end
            OP_LOCKOUT_SECID:
            begin
               c_d.write_enable_latch = 1'b0;
               if (c_q.write_enable_latch)
               begin
                  c_d.secLocked = 1'b1;
                  c_d.secStore  = 1'b1;
               end
            end
            OP_WRITE_STATUS:
            begin
               c_d.write_enable_latch = 1'b0;
               if (c_q.write_enable_latch && !c_q.busy && !c_q.hwProtect)
               begin
                  c_d.pinReconfig = l_q.arg[CFG_PIN_RECONFIG];
                  if (l_q.arg[CFG_WP_ENABLE] != c_q.wpEnable)
                  begin
                     c_d.wpEnable = l_q.arg[CFG_WP_ENABLE];
                     c_d.wpStore  = 1'b1;
                     c_d.wpTimer  = ENABLE_WRITE_COUNT;
                  end
               end
            end
            OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_WRAP_READ, OP_QUAD_PROGRAM:
            begin
               // the field only matters on the single-wire command path
               c_d.quadReject = !c_q.pinReconfig && !fourWireMode;
            end
            default: ;
         endcase
      end

      c_d.busy       = eraseActive || programActive || (c_d.wpTimer != '0);
      // pin serves as data line when reconfigured, so it cannot protect then
      c_d.hwProtect  = c_q.wpEnable && !c_q.syncAcc[0]
                       && !c_q.pinReconfig && !fourWireMode;
      c_d.holdEnable = !c_q.pinReconfig && !fourWireMode;

      // snapshot is frozen while a frame runs so the link reads a steady word;
      // a long status read therefore shows the value from the frame start
      if (c_q.syncAcc[1])
      begin
         c_d.statusSnap = STATUS_RESET;
         c_d.statusSnap[STS_BUSY_LO]   = c_q.busy;
         c_d.statusSnap[STS_BUSY_HI]   = c_q.busy;
         c_d.statusSnap[STS_WEL]       = c_q.write_enable_latch;
         c_d.statusSnap[STS_ERASE_SUS] = c_q.eraseSusp;
         c_d.statusSnap[STS_PROG_SUS]  = c_q.progSusp;
         c_d.statusSnap[STS_LOCKDOWN]  = c_q.lockdown;
         c_d.statusSnap[STS_SEC_LOCK]  = c_q.secLocked;
         c_d.configSnap = '0;
         c_d.configSnap[CFG_PIN_RECONFIG] = c_q.pinReconfig;
         c_d.configSnap[CFG_VOLATILITY]   = !lockBitsAny;
         c_d.configSnap[CFG_WP_ENABLE]    = c_q.wpEnable;
      end

      if (rst)
      begin
         c_d = '0;
         c_d.syncAcc     = 3'h3; // idle levels, so no false command after reset
         c_d.syncA       = 3'h3;
         c_d.syncB       = 3'h3;
         c_d.syncC       = 3'h3;
         c_d.pinReconfig = pinReconfigStrap;
         c_d.wpEnable    = wpEnableStored;
         c_d.secLocked   = secLockedStored;
         c_d.statusSnap  = STATUS_RESET;
         c_d.configSnap  = CONFIG_RESET;
      end
   end

   always_ff @(posedge clk)
      c_q <= c_d;

   assign busyOut        = c_q.busy;
   assign hwWriteProtect = c_q.hwProtect;
   assign holdPinEnable  = c_q.holdEnable;
   assign quadPinsEnable = c_q.pinReconfig;
   assign suspendReq     = c_q.suspendReq;
   assign resumeReq      = c_q.resumeReq;
   assign wpEnableValue  = c_q.wpEnable;
   assign wpEnableStore  = c_q.wpStore;
   assign secLockStore   = c_q.secStore;
   assign quadCmdReject  = c_q.quadReject;

   // ***************************************
   // assertions
   // ***************************************
   property p_eraseSusp;
      (cmdNow && l_q.code == OP_SUSPEND && eraseActive) |=> c_q.eraseSusp ##1 c_q.eraseSusp;
   endproperty
   a_eraseSusp: assert property (p_eraseSusp) else $error("erase suspend flag not set");
   property p_progSusp;
      (cmdNow && l_q.code == OP_SUSPEND && !eraseActive && programActive)
      |=> c_q.progSusp && c_q.suspendReq;
   endproperty
   a_progSusp: assert property (p_progSusp) else $error("program suspend flag not set");
   property p_lockHold;
      c_q.lockdown |=> c_q.lockdown [*3];
   endproperty
   a_lockHold: assert property (p_lockHold) else $error("lock-down flag dropped");
   property p_secHold;
      $rose(c_q.secLocked) |-> c_q.secLocked [*8];
   endproperty
   a_secHold: assert property (p_secHold) else $error("security lock flag dropped");
   property p_busy;
      (eraseActive || programActive) |=> busyOut;
   endproperty
   a_busy: assert property (p_busy) else $error("busy missing during operation");
   property p_cfgReserved;
      $changed(c_q.configSnap) |-> (c_q.configSnap & 8'h75) == 8'h00;
   endproperty
   a_cfgReserved: assert property (p_cfgReserved) else $error("reserved config bit set");
   property p_quadReject;
      (cmdNow && l_q.code == OP_QUAD_IO_READ)
      |=> quadCmdReject == (!$past(c_q.pinReconfig) && !$past(fourWireMode));
   endproperty
   a_quadReject: assert property (p_quadReject) else $error("quad command check wrong");
   property p_wpWriteBusy;
      $rose(wpEnableStore) |-> c_q.wpTimer == ENABLE_WRITE_COUNT ##1 busyOut [*4];
   endproperty
   a_wpWriteBusy: assert property (p_wpWriteBusy) else $error("enable write not busy");
   property p_hwProtect;
      (c_q.wpEnable && !c_q.syncAcc[0] && !c_q.pinReconfig && !fourWireMode)
      ##1 (c_q.wpEnable && !c_q.syncAcc[0] && !c_q.pinReconfig && !fourWireMode)
      |-> hwWriteProtect;
   endproperty
   a_hwProtect: assert property (p_hwProtect) else $error("hardware protect missing");
   property p_welClear;
      (cmdNow && (l_q.code == OP_WRITE_DISABLE || l_q.code == OP_WRITE_STATUS)) |=> !c_q.write_enable_latch;
   endproperty
   a_welClear: assert property (p_welClear) else $error("write latch not cleared");
   property p_cfgBlocked;
      (cmdNow && l_q.code == OP_WRITE_STATUS && c_q.hwProtect) |=> $stable(c_q.pinReconfig);
   endproperty
   a_cfgBlocked: assert property (p_cfgBlocked) else $error("config written under protect");

endmodule

// ===== tb/fscr_host_model.sv
// host controller model for the serial command link
`timescale 1ns/1ps

module fscr_host_model
(
   output logic       spiClk,
   output logic       csN,
   output logic       mosi,
   input  wire logic  miso,
   output logic       rdValid,
   output logic [7:0] rdByte
);
   import fscr_pkg::*;

   initial
   begin
      spiClk  = 1'b0;
      csN     = 1'b1;
      mosi    = 1'b0;
      rdValid = 1'b0;
      rdByte  = 8'h00;
   end

   // ****************************************
   // frames: clock stands low outside them
   // ****************************************
   task automatic frame(input logic [23:0] bits, input int nEdge, input bit rd);
      logic [7:0] sh;
      sh  = 8'h00;
      csN = 1'b0;
      #80;
      for (int i = 0; i < nEdge; i++)
      begin
         mosi = bits[23-i];
         #80 spiClk = 1'b1;
         #80;
         // device shifts after the rising edge, so take the bit on the fall
         if (rd && i >= 7)
            sh = {sh[6:0], miso};
         spiClk = 1'b0;
      end
      rdByte  = sh;
      #80 csN = 1'b1;
      // released line must not keep showing the last bit
      mosi    = ~mosi;
      rdValid = rd;
      #8 rdValid = 1'b0;
      #160;
   endtask

   task automatic cmd(input logic [7:0] op);
      frame({op, 16'h0000}, 8, 1'b0);
   endtask

   task automatic rdReg(input logic [7:0] op);
      frame({op, 16'h0000}, 15, 1'b1);
   endtask

   task automatic wrCfg(input logic [7:0] st, input logic [7:0] cfg);
      cmd(OP_WRITE_ENABLE);
      frame({OP_WRITE_STATUS, st, cfg}, 24, 1'b0);
   endtask

endmodule

// ===== tb/tb_top.sv
// self-checking bench for the status and configuration registers
`timescale 1ns/1ps

module tb_top;
   import fscr_pkg::*;

   logic       clk, rst, spiClk, csN, mosi, miso, misoOe, wpPinN;
   logic       eraseActive, programActive, fourWireMode, lockBitsAny;
   logic       pinReconfigStrap, wpEnableStored, secLockedStored;
   logic       busyOut, hwWriteProtect, holdPinEnable, quadPinsEnable;
   logic       suspendReq, resumeReq, wpEnableValue, wpEnableStore;
   logic       secLockStore, quadCmdReject, rdValid;
   logic [7:0] rdByte;
   logic [7:0] expq [$];
   logic [7:0] quadOps [4];
   int         n_errors, check_count, rejCnt, base, seed, kind, oeCnt;

   fscr_status_config u_fscr_status_config (
      .clk(clk), .rst(rst), .spiClk(spiClk), .csN(csN), .mosi(mosi),
      .miso(miso), .misoOe(misoOe), .wpPinN(wpPinN), .eraseActive(eraseActive),
      .programActive(programActive), .fourWireMode(fourWireMode),
      .lockBitsAny(lockBitsAny), .pinReconfigStrap(pinReconfigStrap),
      .wpEnableStored(wpEnableStored), .secLockedStored(secLockedStored),
      .busyOut(busyOut), .hwWriteProtect(hwWriteProtect),
      .holdPinEnable(holdPinEnable), .quadPinsEnable(quadPinsEnable),
      .suspendReq(suspendReq), .resumeReq(resumeReq),
      .wpEnableValue(wpEnableValue), .wpEnableStore(wpEnableStore),
      .secLockStore(secLockStore), .quadCmdReject(quadCmdReject)
   );

   fscr_host_model u_fscr_host_model (
      .spiClk(spiClk), .csN(csN), .mosi(mosi), .miso(miso),
      .rdValid(rdValid), .rdByte(rdByte)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want)
      begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmd(input logic [7:0] op);
      u_fscr_host_model.cmd(op);
   endtask

   task automatic rd(input logic [7:0] op, input logic [7:0] want);
      expq.push_back(want);
      u_fscr_host_model.rdReg(op);
   endtask

   // status byte is ignored by the device, so it gets random content
   task automatic wcfg(input logic [7:0] v);
      u_fscr_host_model.wrCfg(8'($random(seed)), v);
   endtask

   always @(posedge rdValid)
   begin
      if (expq.size() > 0)
         check(rdByte, expq.pop_front());
      else
      begin
         n_errors++;
         $display("MISMATCH at %0t: read with nothing expected", $time);
      end
   end

   always @(posedge clk)
      if (quadCmdReject === 1'b1)
         rejCnt <= rejCnt + 1;

   // host sample points with the data line driven: eight per read frame
   always @(negedge spiClk)
      if (misoOe === 1'b1)
         oeCnt <= oeCnt + 1;

   // array engine and nonvolatile cells stand in for the rest of the chip
   always @(posedge clk)
   begin
      if (suspendReq === 1'b1)
         {eraseActive, programActive} <= #1 2'b00;
      if (resumeReq === 1'b1)
         {eraseActive, programActive} <= #1 {kind == 0, kind == 1};
      if (wpEnableStore === 1'b1)
         wpEnableStored <= #1 wpEnableValue;
      if (secLockStore === 1'b1)
         secLockedStored <= #1 1'b1;
   end

   initial
   begin
      #400000;
      n_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      wrap_up();
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      seed = 32'h3EC051A1;
      quadOps = '{OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_WRAP_READ, OP_QUAD_PROGRAM};
      {rst, wpPinN} = 2'b11;
      {eraseActive, programActive, fourWireMode, lockBitsAny} = 4'h0;
      {pinReconfigStrap, wpEnableStored, secLockedStored} = 3'h0;
      tick(20);
      rst = 1'b0;
      tick(10);
      rd(OP_READ_CONFIG, 8'h08);
      rd(OP_READ_STATUS, 8'h00);
      check(8'(oeCnt), 8'h10);
      check(8'({quadPinsEnable, holdPinEnable}), 8'h01);
      $display("test defaults done");
      for (int k = 0; k < 2; k++)
      begin
         tick(1);
         kind = k;
         eraseActive = (k == 0);
         programActive = (k == 1);
         tick(3);
         rd(OP_READ_STATUS, 8'h81);
         cmd(OP_WRITE_ENABLE);
         cmd(OP_SUSPEND);
         rd(OP_READ_STATUS, 8'h04 << k);
         cmd(OP_RESUME);
         cmd(OP_WRITE_ENABLE);
         rd(OP_READ_STATUS, 8'h83);
         tick(1);
         {eraseActive, programActive} = 2'b00;
         tick(3);
         rd(OP_READ_STATUS, 8'h00);
      end
      cmd(OP_WRITE_ENABLE);
      rd(OP_READ_STATUS, 8'h02);
      cmd(OP_WRITE_DISABLE);
      rd(OP_READ_STATUS, 8'h00);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_WRITE_PROT);
      rd(OP_READ_STATUS, 8'h00);
      $display("test suspend done");
      for (int m = 0; m < 3; m++)
      begin
         tick(1);
         fourWireMode = (m == 1);
         if (m == 2)
            wcfg(8'($random(seed)) & 8'h7D | 8'h02);
         base = rejCnt;
         foreach (quadOps[j])
            cmd(quadOps[j]);
         check(8'(rejCnt - base), (m == 0) ? 8'h04 : 8'h00);
      end
      rd(OP_READ_CONFIG, 8'h0A);
      check(8'({quadPinsEnable, holdPinEnable}), 8'h02);
      $display("test quad done");
      tick(1);
      wcfg(8'h80);
      check(8'(busyOut), 8'h01);
      for (int t = 0; t < 200 && busyOut !== 1'b0; t++)
         tick(1);
      check(8'({busyOut, wpEnableValue, wpEnableStored}), 8'h03);
      wpPinN = 1'b0;
      tick(8);
      check(8'(hwWriteProtect), 8'h01);
      wcfg(8'h02);
      rd(OP_READ_CONFIG, 8'h88);
      cmd(OP_WRITE_ENABLE);
      rd(OP_READ_STATUS, 8'h02);
      tick(1);
      wpPinN = 1'b1;
      tick(8);
      check(8'(hwWriteProtect), 8'h00);
      $display("test protect done");
      cmd(OP_WRITE_ENABLE);
      cmd(OP_LOCKDOWN_PROT);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_LOCKOUT_SECID);
      rd(OP_READ_STATUS, 8'h30);
      tick(1);
      lockBitsAny = 1'b1;
      pinReconfigStrap = 1'b1;
      tick(2);
      rd(OP_READ_CONFIG, 8'h80);
      tick(1);
      rst = 1'b1;
      tick(20);
      rst = 1'b0;
      tick(10);
      rd(OP_READ_STATUS, 8'h20);
      rd(OP_READ_CONFIG, 8'h82);
      $display("test power cycle done");
      wrap_up();
   end

endmodule
